// [hw/hut_uart_core.sv]
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
// Serial engine shared by both ends: 8N1 framing, stuffed bit timer
module hut_uart_core #(
    parameter int DEPTH = hut_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] divisor,
    input wire logic [7:0] adjust,
    input wire logic rxd,
    input wire logic cts_n,
    output logic txd,
    output logic rts_n,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    output logic rx_overrun
);
    localparam int AW = $clog2(DEPTH);
    typedef enum logic [1:0] {HUT_IDLE, HUT_START, HUT_DATA, HUT_STOP} hut_state_e;

    logic [7:0] txm [DEPTH];
    logic [7:0] rxm [DEPTH];
    logic [AW:0] tx_cnt_q, rx_cnt_q;
    logic [AW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [15:0] bit_len;
    logic [15:0] tx_tmr_q, rx_tmr_q;
    hut_state_e tx_st_q, rx_st_q;
    logic [2:0] tx_bit_q, rx_bit_q;
    logic [7:0] tx_sh_q, rx_sh_q;
    logic rx_push, tx_pop, rx_pop, tx_push;

    function automatic logic [AW-1:0] hut_inc(input logic [AW-1:0] p);
        hut_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : hut_inc

    assign bit_len = hut_pkg::hut_bit_cycles(divisor, adjust);
    assign tx_ready = (tx_cnt_q != (AW+1)'(DEPTH));
    assign tx_push = tx_valid && tx_ready;
    assign rx_valid = (rx_cnt_q != '0);
    assign rx_pop = rx_valid && rx_ready;
    assign tx_pop = (tx_st_q == HUT_IDLE) && (tx_cnt_q != '0) && !cts_n;
    // Margin of one char so a byte already in flight still fits
    assign rts_n = (rx_cnt_q >= (AW+1)'(DEPTH - 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
        end else begin
            if (tx_push) begin
                txm[tx_wp_q] <= tx_data;
                tx_wp_q <= hut_inc(tx_wp_q);
            end
            if (tx_pop) tx_rp_q <= hut_inc(tx_rp_q);
            tx_cnt_q <= tx_cnt_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_st_q <= HUT_IDLE;
            txd <= 1'b1;
            tx_tmr_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= '0;
        end else begin
            unique case (tx_st_q)
                HUT_IDLE: begin
                    txd <= 1'b1;
                    if (tx_pop) begin
                        tx_sh_q <= txm[tx_rp_q];
                        txd <= 1'b0;
                        tx_tmr_q <= bit_len - 16'h0001;
                        tx_st_q <= HUT_START;
                    end
                end
                default: begin
                    if (tx_tmr_q != '0) begin
                        tx_tmr_q <= tx_tmr_q - 16'h0001;
                    end else if (tx_st_q == HUT_STOP) begin
                        tx_st_q <= HUT_IDLE;
                    end else begin
                        tx_tmr_q <= bit_len - 16'h0001;
                        if (tx_st_q == HUT_DATA && tx_bit_q == 3'h7) begin
                            txd <= 1'b1;
                            tx_st_q <= HUT_STOP;
                        end else begin
                            // LSB first
                            txd <= tx_sh_q[0];
                            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
                            tx_bit_q <= (tx_st_q == HUT_START) ? 3'h0 : tx_bit_q + 3'h1;
                            tx_st_q <= HUT_DATA;
                        end
                    end
                end
            endcase
        end
    end

    // Receiver samples at mid bit; start bit is rechecked to reject glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_st_q <= HUT_IDLE;
            rx_tmr_q <= '0;
            rx_bit_q <= '0;
            rx_sh_q <= '0;
            rx_push <= 1'b0;
            rx_overrun <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            rx_overrun <= 1'b0;
            unique case (rx_st_q)
                HUT_IDLE: begin
                    if (!rxd) begin
                        rx_tmr_q <= {1'b0, bit_len[15:1]};
                        rx_st_q <= HUT_START;
                    end
                end
                default: begin
                    if (rx_tmr_q != '0) begin
                        rx_tmr_q <= rx_tmr_q - 16'h0001;
                    end else begin
                        rx_tmr_q <= bit_len - 16'h0001;
                        unique case (rx_st_q)
                            HUT_START: begin
                                rx_st_q <= rxd ? HUT_IDLE : HUT_DATA;
                                rx_bit_q <= '0;
                            end
                            HUT_DATA: begin
                                rx_sh_q <= {rxd, rx_sh_q[7:1]};
                                rx_bit_q <= rx_bit_q + 3'h1;
                                if (rx_bit_q == 3'h7) rx_st_q <= HUT_STOP;
                            end
                            default: begin
                                rx_st_q <= HUT_IDLE;
                                if (rxd) begin
                                    rx_push <= (rx_cnt_q != (AW+1)'(DEPTH));
                                    rx_overrun <= (rx_cnt_q == (AW+1)'(DEPTH));
                                end
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
            rx_data <= '0;
        end else begin
            if (rx_push) begin
                rxm[rx_wp_q] <= rx_sh_q;
                rx_wp_q <= hut_inc(rx_wp_q);
            end
            if (rx_pop) rx_rp_q <= hut_inc(rx_rp_q);
            rx_cnt_q <= rx_cnt_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
            rx_data <= (rx_cnt_q == '0) ? rx_data : rxm[rx_pop ? hut_inc(rx_rp_q) : rx_rp_q];
        end
    end
endmodule : hut_uart_core

// [hw/hut_pkg.sv]
package hut_pkg;
    // Source clock rates
    localparam int SRC_CLK_DEFAULT_HZ = 24_000_000;
    localparam int SRC_CLK_FAST_HZ = 48_000_000;
    // Line rate limits
    localparam int BAUD_MIN_BPS = 38_400;
    localparam int BAUD_MAX_BPS = 4_000_000;
    localparam int BAUD_BOOT_MAX_BPS = 750_000;
    localparam int BAUD_DEFAULT_BPS = 115_200;
    // Clock cycles per bit per divisor step
    localparam int OVERSAMPLE = 16;
    localparam int ADJUST_MAX = 8;
    localparam int FIFO_DEPTH = 1040;
    localparam int DATA_BITS = 8;
    // Divisor for the default rate from a 24 MHz source: 24e6/(16*13) = 115384
    localparam logic [7:0] DIVISOR_RESET = 8'h0D;
    localparam logic [7:0] ADJUST_RESET = 8'h00;
    // Register map of the controller-side register port
    localparam logic [3:0] REG_DIVISOR = 4'h0;
    localparam logic [3:0] REG_ADJUST = 4'h1;
    localparam logic [3:0] REG_CTRL = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_TXDATA = 4'h4;
    localparam logic [3:0] REG_RXDATA = 4'h5;
    localparam int CTRL_FAST_CLK = 0;
    localparam int CTRL_BOOT_DONE = 1;

    // Bit time in source cycles: divisor*16 plus early and late stuffing
    function automatic logic [15:0] hut_bit_cycles(input logic [7:0] div,
                                                   input logic [7:0] adj);
        logic [3:0] lo;
        logic [3:0] hi;
        lo = (adj[3:0] > 4'(ADJUST_MAX)) ? 4'(ADJUST_MAX) : adj[3:0];
        hi = (adj[7:4] > 4'(ADJUST_MAX)) ? 4'(ADJUST_MAX) : adj[7:4];
        hut_bit_cycles = 16'({div, 4'h0}) + 16'(lo) + 16'(hi);
    endfunction : hut_bit_cycles
endpackage : hut_pkg

// [hw/hut_link_if.sv]
`timescale 1ns/100ps
interface hut_link_if;
    logic dev_txd;
    logic dev_rts_n;
    logic host_txd;
    logic host_rts_n;

    modport device (output dev_txd, output dev_rts_n, input host_txd, input host_rts_n);
    modport host (output host_txd, output host_rts_n, input dev_txd, input dev_rts_n);
endinterface : hut_link_if

// [hw/hut_device.sv]
`timescale 1ns/100ps
// Operation
// - Four wires: RX, TX, RTS, CTS
// - Rates from 38400 bps to 4 Mbps; the bit timer tops out at 3 Mbps (48 MHz, divisor 1)
// - Boot phase limited to 750 kbps
// - 1040-byte receive and transmit FIFOs
// - H4 framing, default 115.2 kbaud
// - Source clock 24 MHz, selectable 48 MHz
// - Divisor times sixteen sets bit period
// - Adjust stuffs extra cycles per bit
// - At most eight cycles per half
// - Settings loaded from config record after reset
// - Vendor command updates divisor and adjust
// - Combined rate error within two percent
module hut_device #(
    parameter int DEPTH = hut_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    hut_link_if.device link,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic fast_clk_sel
);
    logic [7:0] divisor_q, adjust_q;
    logic boot_done_q, fast_q;
    logic tx_ready, rx_valid, rx_overrun, ovr_q;
    logic [7:0] rx_data;
    logic rx_pop;
    logic [7:0] div_eff;

    assign fast_clk_sel = fast_q;
    assign rx_pop = rd && (addr == hut_pkg::REG_RXDATA);
    // Before boot completes the divisor is floored at 4 (=375 kbps at 24 MHz)
    assign div_eff = (!boot_done_q && divisor_q < 8'h04) ? 8'h04 : divisor_q;

    // Config record and later vendor commands both land here
    always_ff @(posedge clk) begin
        if (rst) begin
            divisor_q <= hut_pkg::DIVISOR_RESET;
            adjust_q <= hut_pkg::ADJUST_RESET;
            fast_q <= 1'b0;
            boot_done_q <= 1'b0;
        end else if (wr) begin
            unique case (addr)
                hut_pkg::REG_DIVISOR: divisor_q <= (wdata == '0) ? 8'h01 : wdata;
                hut_pkg::REG_ADJUST: adjust_q <= wdata;
                hut_pkg::REG_CTRL: begin
                    fast_q <= wdata[hut_pkg::CTRL_FAST_CLK];
                    boot_done_q <= boot_done_q | wdata[hut_pkg::CTRL_BOOT_DONE];
                end
                default: ;
            endcase
        end
    end

    // Overrun is sticky; a new event beats the clear from a status read
    always_ff @(posedge clk) begin
        if (rst) ovr_q <= 1'b0;
        else if (rx_overrun) ovr_q <= 1'b1;
        else if (rd && addr == hut_pkg::REG_STATUS) ovr_q <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (addr)
                hut_pkg::REG_DIVISOR: rdata <= divisor_q;
                hut_pkg::REG_ADJUST: rdata <= adjust_q;
                hut_pkg::REG_CTRL: rdata <= {6'h00, boot_done_q, fast_q};
                hut_pkg::REG_STATUS: rdata <= {5'h00, ovr_q, rx_valid, tx_ready};
                hut_pkg::REG_RXDATA: rdata <= rx_data;
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    hut_uart_core #(.DEPTH(DEPTH)) u_core (
        .clk(clk),
        .rst(rst),
        .divisor(div_eff),
        .adjust(adjust_q),
        .rxd(link.host_txd),
        .cts_n(link.host_rts_n),
        .txd(link.dev_txd),
        .rts_n(link.dev_rts_n),
        .tx_valid(wr && addr == hut_pkg::REG_TXDATA),
        .tx_data(wdata),
        .tx_ready(tx_ready),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_ready(rx_pop),
        .rx_overrun(rx_overrun)
    );
endmodule : hut_device

// [hw/hut_host.sv]
`timescale 1ns/100ps
// Host end; shares framing so both sides keep the same rate
module hut_host #(
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    hut_link_if.host link,
    input wire logic [7:0] divisor,
    input wire logic [7:0] adjust,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    output logic rx_overrun
);
    hut_uart_core #(.DEPTH(DEPTH)) u_core (
        .clk(clk),
        .rst(rst),
        .divisor(divisor),
        .adjust(adjust),
        .rxd(link.dev_txd),
        .cts_n(link.dev_rts_n),
        .txd(link.host_txd),
        .rts_n(link.host_rts_n),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_ready(rx_ready),
        .rx_overrun(rx_overrun)
    );
endmodule : hut_host

// [sim/hut_link_chk.sv]
`timescale 1ns/100ps
module hut_link_chk #(
    parameter int BIT = 67
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic dev_txd,
    input wire logic dev_rts_n,
    input wire logic host_txd,
    input wire logic host_rts_n
);
    logic dev_prev_q;
    logic host_prev_q;
    logic [15:0] dev_run_q;
    logic [15:0] host_run_q;
    // Runs start at one bit so an early first start bit is legal; saturate on long idle
    always_ff @(posedge clk) begin
        if (rst) begin
            dev_prev_q <= 1'b1;
            dev_run_q <= 16'(BIT);
        end else begin
            dev_prev_q <= dev_txd;
            dev_run_q <= (dev_txd != dev_prev_q) ? 16'h0001 : dev_run_q + {15'h0, ~&dev_run_q};
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            host_prev_q <= 1'b1;
            host_run_q <= 16'(BIT);
        end else begin
            host_prev_q <= host_txd;
            host_run_q <= (host_txd != host_prev_q) ? 16'h0001
                : host_run_q + {15'h0, ~&host_run_q};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    link_idle_a: assert property ($fell(rst) |-> dev_txd && host_txd)
        else $error("line not idle after reset");
    rts_reset_a: assert property ($fell(rst) |-> !dev_rts_n && !host_rts_n)
        else $error("rts not asserted after reset");
    dev_bit_len_a: assert property (dev_txd && !dev_prev_q |-> (dev_run_q % BIT) == 0)
        else $error("device low run not whole bits");
    dev_frame_len_a: assert property (dev_txd && !dev_prev_q |-> dev_run_q <= 16'(9 * BIT))
        else $error("device low run too long");
    dev_gap_a: assert property (!dev_txd && dev_prev_q |-> dev_run_q >= 16'(BIT))
        else $error("device high run shorter than a bit");
    host_bit_len_a: assert property (host_txd && !host_prev_q |-> (host_run_q % BIT) == 0)
        else $error("host low run not whole bits");
    host_frame_len_a: assert property (host_txd && !host_prev_q |-> host_run_q <= 16'(9 * BIT))
        else $error("host low run too long");
    host_cts_hold_a: assert property (host_prev_q && host_run_q > 16'(9 * BIT) && dev_rts_n
        && $past(dev_rts_n) && $past(dev_rts_n, 2) |-> host_txd)
        else $error("host started while held off");
endmodule : hut_link_chk

// [sim/testbench.sv]
`timescale 1ns/100ps
module testbench;
    localparam int BIT = 4 * hut_pkg::OVERSAMPLE + 1 + 2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic fast_clk_sel;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic rx_ready = 1'b0;
    logic rx_overrun;
    logic [7:0] v;
    int fail_count = 0;
    int tests_run = 0;
    int n;
    hut_link_if link ();
    hut_device #(.DEPTH(8)) u_hut_device (.clk(clk), .rst(rst), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fast_clk_sel(fast_clk_sel));
    // Host runs at the rate the device is switched to before any traffic
    hut_host u_hut_host (.clk(clk), .rst(rst), .link(link), .divisor(8'h04), .adjust(8'h21),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .rx_overrun(rx_overrun));
    hut_link_chk #(.BIT(BIT)) u_hut_link_chk (.clk(clk), .rst(rst), .dev_txd(link.dev_txd),
        .dev_rts_n(link.dev_rts_n), .host_txd(link.host_txd), .host_rts_n(link.host_rts_n));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic final_report();
        $display("Checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bound(input int i);
        if (i > 20000) begin
            fail_count++;
            final_report();
        end
    endtask : bound
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask : rd_reg
    task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
        rd_reg(a);
        chk(what, v, exp);
    endtask : rd_chk
    task automatic wait_rx();
        v = 8'h00;
        for (n = 0; v[1] !== 1'b1; n++) begin
            rd_reg(hut_pkg::REG_STATUS);
            bound(n);
        end
    endtask : wait_rx
    task automatic host_get(input logic [7:0] exp);
        // Step off the pop edge first: rx_valid there still shows the old count
        @(negedge clk);
        for (n = 0; rx_valid !== 1'b1; n++) begin
            @(negedge clk);
            bound(n);
        end
        @(negedge clk);
        chk("host_rx", rx_data, exp);
        chk("host_ovr", {7'h00, rx_overrun}, 8'h00);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask : host_get
    // Samples the device line at mid-bit, least significant bit first
    task automatic wire_frame(input logic [7:0] b);
        for (n = 0; link.dev_txd !== 1'b0; n++) begin
            @(negedge clk);
            bound(n);
        end
        repeat (BIT / 2) @(negedge clk);
        chk("start", {7'h00, link.dev_txd}, 8'h00);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge clk);
            chk("data_bit", {7'h00, link.dev_txd}, {7'h00, b[i]});
        end
        repeat (BIT) @(negedge clk);
        chk("stop", {7'h00, link.dev_txd}, 8'h01);
    endtask : wire_frame
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk("divisor", hut_pkg::REG_DIVISOR, hut_pkg::DIVISOR_RESET);
        rd_chk("adjust", hut_pkg::REG_ADJUST, hut_pkg::ADJUST_RESET);
        rd_chk("status", hut_pkg::REG_STATUS, 8'h01);
        rd_chk("unmapped", 4'hF, 8'h00);
        wr_reg(hut_pkg::REG_CTRL, 8'h03);
        chk("fast_clk", {7'h00, fast_clk_sel}, 8'h01);
        wr_reg(hut_pkg::REG_CTRL, 8'h00);
        chk("fast_clk", {7'h00, fast_clk_sel}, 8'h00);
        rd_chk("ctrl", hut_pkg::REG_CTRL, 8'h02);
        wr_reg(hut_pkg::REG_DIVISOR, 8'h00);
        rd_chk("div_zero", hut_pkg::REG_DIVISOR, 8'h01);
        wr_reg(hut_pkg::REG_DIVISOR, 8'h04);
        wr_reg(hut_pkg::REG_ADJUST, 8'h21);
        rd_chk("divisor", hut_pkg::REG_DIVISOR, 8'h04);
        rd_chk("adjust", hut_pkg::REG_ADJUST, 8'h21);
        wr_reg(hut_pkg::REG_TXDATA, 8'hA5);
        wr_reg(hut_pkg::REG_TXDATA, 8'h00);
        wr_reg(hut_pkg::REG_TXDATA, 8'hFF);
        wire_frame(8'hA5);
        host_get(8'hA5);
        host_get(8'h00);
        host_get(8'hFF);
        tx_valid <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            tx_data <= 8'h30 + 8'(i);
            @(negedge clk);
            chk("tx_ready", {7'h00, tx_ready}, 8'h01);
            @(posedge clk);
        end
        tx_valid <= 1'b0;
        for (n = 0; link.dev_rts_n !== 1'b1; n++) begin
            @(negedge clk);
            bound(n);
        end
        repeat (1500) @(negedge clk);
        chk("host_hold", {7'h00, link.host_txd}, 8'h01);
        rd_chk("status_full", hut_pkg::REG_STATUS, 8'h03);
        for (int i = 0; i < 10; i++) begin
            wait_rx();
            rd_chk("rx_byte", hut_pkg::REG_RXDATA, 8'h30 + 8'(i));
        end
        rd_chk("status_end", hut_pkg::REG_STATUS, 8'h01);
        final_report();
    end
endmodule : testbench
